// *** common/pspace_pkg.sv ***
// constants and carrier types of the program space address generator
package pspace_pkg;

    // -------------------------------------------------------------------
    // widths
    // -------------------------------------------------------------------
    localparam int unsigned PADDR_W = 24;
    localparam int unsigned PC_W = 23;
    localparam int unsigned EA_W = 16;
    localparam int unsigned PAGE_W = 8;
    localparam int unsigned PWORD_W = 24;
    localparam int unsigned DWORD_W = 16;
    localparam int unsigned VIS_LOW_W = 15;
    localparam int unsigned AXI_ADDR_W = 8;
    localparam int unsigned AXI_DATA_W = 32;

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int unsigned CFG_SEL_BIT = 7;
    localparam int unsigned EA_TOP_BIT = 15;
    localparam int unsigned ST_CFG_BIT = 24;
    localparam int unsigned ST_DENIED_BIT = 25;
    localparam int unsigned ST_ZERO_BIT = 26;

    // -------------------------------------------------------------------
    // register map (byte addresses) and reset values
    // -------------------------------------------------------------------
    localparam logic [7:0] REG_TABLE_PAGE = 8'h00;
    localparam logic [7:0] REG_VIS_PAGE = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] TABLE_PAGE_RESET = 8'h00;
    localparam logic [7:0] VIS_PAGE_RESET = 8'h00;
    localparam logic [23:0] USER_LIMIT_DEFAULT = 24'h015800;
    localparam logic [23:0] USER_SPACE_END = 24'h800000;

    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // -------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        op_fetch = 3'b000,
        op_table_read_op = 3'b001,
        op_table_write_op = 3'b010,
        op_data_read = 3'b011,
        op_data_write = 3'b100
    } op_t;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_issue = 2'b01,
        st_capture = 2'b10,
        st_done = 2'b11
    } st_t;

    typedef struct packed {
        logic valid;
        op_t op;
        logic upper;
        logic byte_mode;
        logic [EA_W-1:0] ea;
        logic [PC_W-1:0] pc;
        logic [DWORD_W-1:0] wdata;
    } cpu_req_t;

    typedef struct packed {
        logic valid;
        logic [PWORD_W-1:0] data;
        logic denied;
        logic zero;
    } cpu_resp_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [PADDR_W-1:0] addr;
        logic [PWORD_W-1:0] wdata;
        logic [2:0] be;
    } flash_req_t;

endpackage : pspace_pkg

// *** hdl/program_space_address_gen.sv ***
// program space address generator with its page registers on AXI4-Lite
//
// Contract
// - program addresses 24 bits, fetch from 23-bit counter
// - user code confined to lower half of space
// - table address is table page joined with address
// - table page top bit picks configuration memory
// - remap joins visibility page with low fifteen bits
// - remapped accesses never reach configuration memory
// - remapped window is read-only, writes refused
// - remapped read returns low sixteen bits only
// - table ops reach every byte, byte or word
// - 24-bit program words, 16-bit data, alignment kept
// - remap ignores address bit 15, uses page bit
`timescale 1ns/1ps
`default_nettype none

module program_space_address_gen
    import pspace_pkg::*;
#(
    parameter logic [23:0] USER_LIMIT = pspace_pkg::USER_LIMIT_DEFAULT
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire pspace_pkg::cpu_req_t req,
    output logic req_ready,
    output pspace_pkg::cpu_resp_t resp,
    output pspace_pkg::flash_req_t flash,
    input wire logic [pspace_pkg::PWORD_W-1:0] flash_rdata,
    input wire logic awvalid,
    output logic awready,
    input wire logic [pspace_pkg::AXI_ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [pspace_pkg::AXI_DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [pspace_pkg::AXI_ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [pspace_pkg::AXI_DATA_W-1:0] rdata,
    output logic [1:0] rresp
);
    import pspace_pkg::*;

    // -------------------------------------------------------------------
    // parameter check
    // -------------------------------------------------------------------
    generate
        if (USER_LIMIT > USER_SPACE_END) begin : g_bad_limit
            $error("user limit lies beyond the user half of program space");
        end
    endgenerate

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        st_t st;
        logic req_ready;
        logic [PAGE_W-1:0] table_page;
        logic [PAGE_W-1:0] visibility_page;
        flash_req_t flash;
        cpu_resp_t resp;
        op_t op;
        logic upper;
        logic byte_mode;
        logic lsb;
        logic [PADDR_W-1:0] last_addr;
        logic last_cfg;
        logic last_denied;
        logic last_zero;
        logic awready;
        logic aw_held;
        logic [AXI_ADDR_W-1:0] aw_addr;
        logic wready;
        logic w_held;
        logic [AXI_DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [AXI_DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } state_t;

    function automatic state_t reset_value();
        state_t r;
        r = '0;
        r.st = st_idle;
        r.req_ready = 1'b1;
        r.table_page = TABLE_PAGE_RESET;
        r.visibility_page = VIS_PAGE_RESET;
        r.awready = 1'b1;
        r.wready = 1'b1;
        r.arready = 1'b1;
        return r;
    endfunction : reset_value

    localparam state_t STATE_RESET = reset_value();

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    // register index: 0 table page, 1 visibility page, 2 status, 3 none
    function automatic logic [1:0] reg_index(input logic [7:0] a);
        logic [1:0] idx;
        idx = 2'h3;
        if (a == REG_TABLE_PAGE) begin
            idx = 2'h0;
        end else if (a == REG_VIS_PAGE) begin
            idx = 2'h1;
        end else if (a == REG_STATUS) begin
            idx = 2'h2;
        end
        return idx;
    endfunction : reg_index

    // picks the lanes of a program word that the access asked for
    function automatic logic [PWORD_W-1:0] shape(
        input op_t op,
        input logic upper,
        input logic byte_mode,
        input logic lsb,
        input logic [PWORD_W-1:0] w
    );
        logic [PWORD_W-1:0] d;
        d = '0;
        unique case (op)
            op_fetch: begin
                d = w;
            end
            op_data_read: begin
                d = {8'h00, w[15:0]};
            end
            op_table_read_op: begin
                if (upper) begin
                    d = {16'h0000, w[23:16]};
                end else if (byte_mode) begin
                    d = {16'h0000, (lsb ? w[15:8] : w[7:0])};
                end else begin
                    d = {8'h00, w[15:0]};
                end
            end
            default: begin
                d = '0;
            end
        endcase
        return d;
    endfunction : shape

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    state_t s;
    state_t next_s;

    always_comb begin
        logic [PADDR_W-1:0] a;
        logic want_rd;
        logic want_wr;
        logic refuse;
        logic present;
        a = '0;
        want_rd = 1'b0;
        want_wr = 1'b0;
        refuse = 1'b0;
        present = 1'b0;
        next_s = s;
        next_s.flash.rd = 1'b0;
        next_s.flash.wr = 1'b0;

        // register bus, write side: address and data in either order
        if (awvalid && s.awready) begin
            next_s.aw_addr = awaddr;
            next_s.aw_held = 1'b1;
            next_s.awready = 1'b0;
        end
        if (wvalid && s.wready) begin
            next_s.wdata = wdata;
            next_s.wstrb = wstrb;
            next_s.w_held = 1'b1;
            next_s.wready = 1'b0;
        end
        if (s.aw_held && s.w_held && !s.bvalid) begin
            next_s.bvalid = 1'b1;
            next_s.bresp = AXI_OKAY;
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            unique case (reg_index(s.aw_addr))
                2'h0: begin
                    if (s.wstrb[0]) begin
                        next_s.table_page = s.wdata[PAGE_W-1:0];
                    end
                end
                2'h1: begin
                    if (s.wstrb[0]) begin
                        next_s.visibility_page = s.wdata[PAGE_W-1:0];
                    end
                end
                2'h2: begin
                    // status is read-only; the write is dropped quietly
                end
                2'h3: begin
                    next_s.bresp = AXI_SLVERR;
                end
            endcase
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
            next_s.awready = 1'b1;
            next_s.wready = 1'b1;
        end

        // register bus, read side
        if (arvalid && s.arready) begin
            next_s.arready = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.rresp = AXI_OKAY;
            unique case (reg_index(araddr))
                2'h0: begin
                    next_s.rdata = {24'h000000, s.table_page};
                end
                2'h1: begin
                    next_s.rdata = {24'h000000, s.visibility_page};
                end
                2'h2: begin
                    next_s.rdata = '0;
                    next_s.rdata[PADDR_W-1:0] = s.last_addr;
                    next_s.rdata[ST_CFG_BIT] = s.last_cfg;
                    next_s.rdata[ST_DENIED_BIT] = s.last_denied;
                    next_s.rdata[ST_ZERO_BIT] = s.last_zero;
                end
                2'h3: begin
                    next_s.rdata = '0;
                    next_s.rresp = AXI_SLVERR;
                end
            endcase
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
            next_s.arready = 1'b1;
        end

        // access sequencer
        unique case (s.st)
            st_idle: begin
                if (req.valid) begin
                    next_s.req_ready = 1'b0;
                    next_s.op = req.op;
                    next_s.upper = req.upper;
                    next_s.byte_mode = req.byte_mode;
                    next_s.lsb = req.ea[0];
                    unique case (req.op)
                        op_fetch: begin
                            // top bit forced low keeps fetches in user space
                            a = {1'b0, req.pc[PC_W-1:1], 1'b0};
                            want_rd = 1'b1;
                        end
                        op_table_read_op: begin
                            a = {s.table_page, req.ea};
                            want_rd = 1'b1;
                        end
                        op_table_write_op: begin
                            a = {s.table_page, req.ea};
                            want_wr = 1'b1;
                        end
                        op_data_read: begin
                            if (req.ea[EA_TOP_BIT]) begin
                                // ea bit 15 dropped, page bit 0 lands there
                                a = {1'b0, s.visibility_page,
                                     req.ea[VIS_LOW_W-1:0]};
                                want_rd = 1'b1;
                            end else begin
                                refuse = 1'b1;
                            end
                        end
                        op_data_write: begin
                            refuse = 1'b1;
                        end
                        default: begin
                            refuse = 1'b1;
                        end
                    endcase
                    present = a[CFG_SEL_BIT+16] || (a < USER_LIMIT);
                    next_s.last_addr = a;
                    next_s.last_cfg = a[CFG_SEL_BIT+16];
                    next_s.last_denied = refuse;
                    next_s.last_zero = want_rd && !present;
                    next_s.resp = '0;
                    next_s.st = st_done;
                    if (want_rd && present) begin
                        next_s.flash.rd = 1'b1;
                        next_s.flash.addr = a;
                        next_s.st = st_issue;
                    end else if (want_wr && present) begin
                        next_s.flash.wr = 1'b1;
                        next_s.flash.addr = a;
                        if (req.upper) begin
                            next_s.flash.wdata = {req.wdata[7:0], 16'h0000};
                            next_s.flash.be = 3'b100;
                        end else if (req.byte_mode) begin
                            next_s.flash.wdata = {8'h00, req.wdata[7:0],
                                                  req.wdata[7:0]};
                            next_s.flash.be = req.ea[0] ? 3'b010 : 3'b001;
                        end else begin
                            next_s.flash.wdata = {8'h00, req.wdata};
                            next_s.flash.be = 3'b011;
                        end
                        next_s.resp.valid = 1'b1;
                    end else begin
                        // unimplemented reads answer zero without error
                        next_s.resp.valid = 1'b1;
                        next_s.resp.denied = refuse;
                        next_s.resp.zero = want_rd;
                    end
                end
            end
            st_issue: begin
                // flash answers one cycle after its read strobe
                next_s.st = st_capture;
            end
            st_capture: begin
                next_s.resp.valid = 1'b1;
                next_s.resp.data = shape(s.op, s.upper, s.byte_mode, s.lsb,
                                         flash_rdata);
                next_s.st = st_done;
            end
            st_done: begin
                next_s.resp.valid = 1'b0;
                next_s.req_ready = 1'b1;
                next_s.st = st_idle;
            end
        endcase
    end

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s <= STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // -------------------------------------------------------------------
    // outputs, all straight from the state register
    // -------------------------------------------------------------------
    assign req_ready = s.req_ready;
    assign resp = s.resp;
    assign flash = s.flash;
    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;

endmodule : program_space_address_gen

`default_nettype wire

// *** verif/program_space_address_gen_chk.sv ***
// port assertions for the program space address generator
`timescale 1ns/1ps
`default_nettype none

module program_space_address_gen_chk
    import pspace_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire pspace_pkg::cpu_req_t req,
    input wire logic req_ready,
    input wire pspace_pkg::cpu_resp_t resp,
    input wire pspace_pkg::flash_req_t flash
);
    import pspace_pkg::*;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    logic take;
    assign take = req.valid && req_ready;

    // ------
    // addressing, refusals, lanes, read timing and zero reads
    // ------
    a_fetch_addr: assert property (
        take && req.op == op_fetch |=> !flash.rd
        || flash.addr == {1'b0, $past(req.pc[22:1]), 1'b0})
        else $error("fetch address wrong");
    a_table_addr: assert property (
        take && req.op inside {op_table_read_op, op_table_write_op}
        |=> !(flash.rd || flash.wr) || flash.addr[15:0] == $past(req.ea))
        else $error("table address low half wrong");
    a_remap_addr: assert property (
        take && req.op == op_data_read && req.ea[15] |=> !flash.rd
        || (!flash.addr[23] && flash.addr[14:0] == $past(req.ea[14:0])))
        else $error("remap address wrong");
    a_remap_no_write: assert property (
        take && req.op == op_data_write
        |=> resp.valid && resp.denied && !flash.wr)
        else $error("remap write not refused");
    a_remap_low_word: assert property (
        take && req.op == op_data_read && req.ea[15] ##1 flash.rd
        |-> ##2 resp.valid && resp.data[23:16] == 8'h00)
        else $error("remap read upper byte leaked");
    a_read_timing: assert property (
        flash.rd |=> !flash.rd ##1 resp.valid)
        else $error("flash read answer late");
    a_byte_lanes: assert property (
        take && req.op == op_table_write_op && req.byte_mode && !req.upper
        |=> !flash.wr || flash.be == ($past(req.ea[0]) ? 3'b010 : 3'b001))
        else $error("byte write lane wrong");
    a_zero_read: assert property (
        resp.valid && resp.zero |-> resp.data == 24'h000000 && !resp.denied)
        else $error("unimplemented read not zero");

endmodule : program_space_address_gen_chk

`default_nettype wire

// *** verif/flash_model.sv ***
// behavioural program flash that answers reads with an address-derived word
`timescale 1ns/1ps
`default_nettype none

module flash_model
    import pspace_pkg::*;
(
    input wire logic mclk,
    input wire pspace_pkg::flash_req_t flash,
    output logic [pspace_pkg::PWORD_W-1:0] flash_rdata
);
    import pspace_pkg::*;

    initial flash_rdata = 24'h5A5A5A;

    // the word is good for one cycle only; it flips afterwards so a late
    // sample shows garbage instead of a lucky stale match
    always @(posedge mclk) begin
        if (flash.rd) begin
            flash_rdata <= flash.addr ^ 24'hC3A55A;
        end else begin
            flash_rdata <= ~flash_rdata;
        end
    end

endmodule : flash_model

`default_nettype wire

// *** verif/program_space_address_gen_test.sv ***
// self-checking bench for the program space address generator
`timescale 1ns/1ps
`default_nettype none

module program_space_address_gen_test;
    import pspace_pkg::*;

    logic mclk = 1'b0;
    logic rstn = 1'b0;
    cpu_req_t req = '0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic req_ready, awready, wready, bvalid, arready, rvalid, resp_valid;
    logic aw_w;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [23:0] flash_rdata;
    cpu_resp_t resp, got;
    flash_req_t flash, fl;
    int n_errors = 0;
    int n_tests = 0;

    always #50 mclk = ~mclk;
    assign resp_valid = resp.valid;
    assign aw_w = awready && wready;

    program_space_address_gen i_dut (
        .mclk(mclk), .rstn(rstn), .req(req), .req_ready(req_ready),
        .resp(resp), .flash(flash), .flash_rdata(flash_rdata),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
    );
    flash_model i_flash (.mclk(mclk), .flash(flash),
        .flash_rdata(flash_rdata));

    // ------
    // helpers
    // ------
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] seen);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic c24(input string what, input logic [23:0] exp,
                       input logic [23:0] seen);
        check(what, {8'h00, exp}, {8'h00, seen});
    endtask : c24

    // bounded wait, sampled mid-cycle where outputs have settled
    task automatic wait_hi(ref logic s, input string what);
        int n;
        n = 0;
        do @(negedge mclk); while (s !== 1'b1 && ++n < 20);
        if (s !== 1'b1) begin
            check(what, 32'h1, 32'h0);
            finish_test();
        end
    endtask : wait_hi

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] exp_resp);
        @(posedge mclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        bready <= 1'b1;
        wait_hi(aw_w, "awready");
        @(posedge mclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        wait_hi(bvalid, "bvalid");
        check("bresp", {30'h0, exp_resp}, {30'h0, bresp});
        @(posedge mclk);
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp,
                          input logic [1:0] exp_resp, input string what);
        @(posedge mclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        wait_hi(arready, "arready");
        @(posedge mclk);
        arvalid <= 1'b0;
        wait_hi(rvalid, "rvalid");
        check(what, exp, rdata);
        check("rresp", {30'h0, exp_resp}, {30'h0, rresp});
        @(posedge mclk);
        rready <= 1'b0;
    endtask : axi_rd

    task automatic cpu(input op_t op, input logic up, input logic bm,
                       input logic [15:0] ea, input logic [15:0] wd);
        @(posedge mclk);
        req <= '{valid: 1'b1, op: op, upper: up, byte_mode: bm, ea: ea,
                 pc: {7'h00, ea}, wdata: wd};
        wait_hi(req_ready, "req_ready");
        @(posedge mclk);
        req.valid <= 1'b0;
        wait_hi(resp_valid, "resp");
        got = resp;
        fl = flash;
    endtask : cpu

    function automatic logic [23:0] pat(input logic [23:0] a);
        return a ^ 24'hC3A55A;
    endfunction : pat

    // ------
    // sequence
    // ------
    initial begin
        logic [23:0] w;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        axi_rd(REG_TABLE_PAGE, 32'h0, AXI_OKAY, "table_page");
        axi_rd(REG_VIS_PAGE, 32'h0, AXI_OKAY, "visibility_page");
        axi_rd(REG_STATUS, 32'h0, AXI_OKAY, "status");
        axi_rd(8'h0C, 32'h0, AXI_SLVERR, "unmapped read");
        axi_wr(8'h0C, 32'h0, AXI_SLVERR);
        axi_wr(REG_TABLE_PAGE, 32'h01, AXI_OKAY);
        axi_wr(REG_VIS_PAGE, 32'h01, AXI_OKAY);
        axi_rd(REG_TABLE_PAGE, 32'h01, AXI_OKAY, "table_page");
        $display("test registers done");
        cpu(op_fetch, 1'b0, 1'b0, 16'h1235, 16'h0);
        c24("fetch addr", 24'h001234, fl.addr);
        c24("fetch data", pat(24'h001234), got.data);
        w = pat(24'h012344);
        cpu(op_table_read_op, 1'b0, 1'b0, 16'h2344, 16'h0);
        c24("table addr", 24'h012344, fl.addr);
        c24("table word", {8'h00, w[15:0]}, got.data);
        cpu(op_table_read_op, 1'b0, 1'b1, 16'h2344, 16'h0);
        c24("low byte", {16'h0, w[7:0]}, got.data);
        cpu(op_table_read_op, 1'b1, 1'b0, 16'h2344, 16'h0);
        c24("upper byte", {16'h0, w[23:16]}, got.data);
        w = pat(24'h012345);
        cpu(op_table_read_op, 1'b0, 1'b1, 16'h2345, 16'h0);
        c24("odd byte", {16'h0, w[15:8]}, got.data);
        $display("test table reads done");
        axi_wr(REG_TABLE_PAGE, 32'h80, AXI_OKAY);
        cpu(op_table_read_op, 1'b0, 1'b0, 16'h0004, 16'h0);
        c24("config addr", 24'h800004, fl.addr);
        axi_rd(REG_STATUS, 32'h01800004, AXI_OKAY, "status");
        axi_wr(REG_TABLE_PAGE, 32'h02, AXI_OKAY);
        cpu(op_table_read_op, 1'b0, 1'b0, 16'h0000, 16'h0);
        c24("zero flags", 24'h2, {22'h0, got.zero, got.denied});
        c24("zero data", 24'h0, got.data);
        axi_rd(REG_STATUS, 32'h04020000, AXI_OKAY, "status");
        $display("test config and unimplemented done");
        axi_wr(REG_TABLE_PAGE, 32'h01, AXI_OKAY);
        cpu(op_table_write_op, 1'b0, 1'b0, 16'h0100, 16'hBEEF);
        c24("word write", 24'h0BBEEF, {fl.wr, fl.be, fl.wdata[15:0]});
        c24("write addr", 24'h010100, fl.addr);
        cpu(op_table_write_op, 1'b0, 1'b1, 16'h0101, 16'h00A7);
        c24("byte write", 24'h0AA7A7, {fl.wr, fl.be, fl.wdata[15:0]});
        cpu(op_table_write_op, 1'b1, 1'b0, 16'h0100, 16'h005C);
        c24("upper write", 24'h0C005C,
            {fl.wr, fl.be, 8'h00, fl.wdata[23:16]});
        $display("test table writes done");
        w = pat(24'h00C123);
        cpu(op_data_read, 1'b0, 1'b0, 16'hC123, 16'h0);
        c24("remap addr", 24'h00C123, fl.addr);
        c24("remap data", {8'h00, w[15:0]}, got.data);
        cpu(op_data_read, 1'b0, 1'b0, 16'h4123, 16'h0);
        c24("low half denied", 24'h1, {23'h0, got.denied});
        cpu(op_data_write, 1'b0, 1'b0, 16'hC123, 16'h1234);
        c24("remap write", 24'h2, {22'h0, got.denied, fl.wr});
        axi_wr(REG_VIS_PAGE, 32'h81, AXI_OKAY);
        cpu(op_data_read, 1'b0, 1'b0, 16'h8000, 16'h0);
        axi_rd(REG_STATUS, 32'h04408000, AXI_OKAY, "status");
        $display("test remap done");
        finish_test();
    end

endmodule : program_space_address_gen_test

bind program_space_address_gen program_space_address_gen_chk i_chk (
    .mclk(mclk), .rstn(rstn), .req(req), .req_ready(req_ready),
    .resp(resp), .flash(flash)
);

`default_nettype wire
